//--- sdbmd_top.sv
`default_nettype none
`include "sdbmd_cfg.svh"

// ****************************************************************
// Command decode and burst engine
// ****************************************************************
module sdbmd_top #(
  parameter int DQ_W = 16  // Organisation: 4, 8 or 16 data bits
) (
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  input  wire logic                      clk_en,
  input  wire logic                      cke,
  input  wire sdbmd_pkg::sdbmd_pins_t    cmd,
  input  wire logic                      bank_select_0,
  input  wire logic                      bank_select_1,
  input  wire logic [11:0]               addr,
  input  wire logic [`SDBMD_DM_MAX-1:0]  dqm,
  input  wire logic [`SDBMD_DQ_MAX-1:0]  dq_in,
  input  wire logic [`SDBMD_DQ_MAX-1:0]  arr_rdata,
  output logic      [`SDBMD_DQ_MAX-1:0]  dq_out,
  output logic      [`SDBMD_DM_MAX-1:0]  dq_oe,
  output sdbmd_pkg::sdbmd_arr_t          arr_req,
  output logic      [3:0]                bank_open,
  output logic                           self_refresh,
  output logic                           mode_reserved
);

  // ****************************************************************
  // Organisation
  // ****************************************************************
  // Column bits per organisation; page is two to this power
  localparam int COL_W = (DQ_W == 4) ? 11 : (DQ_W == 8) ? 10 : 9;
  localparam logic [`SDBMD_COL_MAX-1:0] PAGE_MASK =
    `SDBMD_COL_MAX'((1 << COL_W) - 1);

  // Refuse organisations the decoder cannot serve
  if (!(DQ_W == 4 || DQ_W == 8 || DQ_W == 16)) begin : g_bad_org
    $error("DQ_W must be 4, 8 or 16");
  end

  // ****************************************************************
  // Declarations
  // ****************************************************************
  sdbmd_pkg::sdbmd_state_t   q;         // Registered state
  sdbmd_pkg::sdbmd_state_t   d;         // Next state
  logic [1:0]                bsel;      // Bank pins as an index
  logic [2:0]                bl_code;   // Burst length field
  logic [2:0]                rl_code;   // Read latency field
  logic                      lat3;      // Latency of three clocks
  logic                      normal;    // Operating mode is normal
  logic [`SDBMD_COL_MAX-1:0] bl_last;   // Beats minus one
  logic [`SDBMD_COL_MAX-1:0] col_cmd;   // Start column from pins
  logic [`SDBMD_COL_MAX-1:0] col_next;  // Column of the next beat
  logic [`SDBMD_COL_MAX-1:0] beat_nx;   // Next beat number
  logic                      c_act;     // Decoded commands
  logic                      c_rd;
  logic                      c_wr;
  logic                      c_bst;
  logic                      c_pre;
  logic                      c_ref;
  logic                      c_mrs;

  // ****************************************************************
  // Decode
  // ****************************************************************
  assign bsel    = {bank_select_1, bank_select_0};
  assign bl_code = q.mode[`SDBMD_BL_MSB:`SDBMD_BL_LSB];
  assign rl_code = q.mode[`SDBMD_RL_MSB:`SDBMD_RL_LSB];
  // A reserved latency code is undefined; it behaves as three
  assign lat3    = (rl_code != `SDBMD_RL_2);
  assign normal  =
    (q.mode[`SDBMD_OPM_MSB:`SDBMD_OPM_LSB] == `SDBMD_OPM_NORMAL);

  // Column pins skip the precharge pin; mask trims per organisation
  assign col_cmd = {addr[`SDBMD_AP_BIT+1], addr[`SDBMD_AP_BIT-1:0]}
                   & PAGE_MASK;
  assign beat_nx = q.beat + 1'b1;

  // Strobe patterns; select high is inhibit and decodes nothing
  always_comb begin
    c_act = 1'b0;
    c_rd  = 1'b0;
    c_wr  = 1'b0;
    c_bst = 1'b0;
    c_pre = 1'b0;
    c_ref = 1'b0;
    c_mrs = 1'b0;
    if (!cmd.cs_n) begin
      unique case ({cmd.ras_n, cmd.cas_n, cmd.we_n})
        3'h3: c_act = 1'b1;
        3'h5: c_rd  = 1'b1;
        3'h4: c_wr  = 1'b1;
        3'h6: c_bst = 1'b1;
        3'h2: c_pre = 1'b1;
        3'h1: c_ref = 1'b1;
        3'h0: c_mrs = 1'b1;
        3'h7: c_act = 1'b0;  // No operation
      endcase
    end
  end

  // Last beat number for the programmed length
  always_comb begin
    unique case (bl_code)
      `SDBMD_BL_2:    bl_last = `SDBMD_LAST_2;
      `SDBMD_BL_4:    bl_last = `SDBMD_LAST_4;
      `SDBMD_BL_8:    bl_last = `SDBMD_LAST_8;
      `SDBMD_BL_FULL: bl_last = PAGE_MASK;
      default:        bl_last = '0;        // Length one or reserved
    endcase
  end

  // ****************************************************************
  // Column order
  // ****************************************************************
  sdbmd_order #(
    .COL_W     (COL_W)
  ) u_order (
    .start     (q.start),
    .beat      (beat_nx),
    .bl_code   (bl_code),
    .ilv       (q.mode[`SDBMD_BT_BIT]),
    .page_mask (PAGE_MASK),
    .col       (col_next)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d = q;
    d.arr.valid   = 1'b0;
    d.arr.refresh = 1'b0;
    // Mask of the last edge; the output flop adds the second clock
    d.dqm_q1  = dqm;
    // Array answers in the cycle after the column; keep one copy
    d.rd_data = arr_rdata;
    d.rd_vld  = q.arr.valid && !q.arr.write && !q.arr.refresh;
    // Output stage: latency two skips the extra copy
    if (lat3) begin
      d.dq_out = q.rd_data;
      d.dq_oe  = q.rd_vld ? ~q.dqm_q1 : '0;
    end else begin
      d.dq_out = arr_rdata;
      d.dq_oe  = d.rd_vld ? ~q.dqm_q1 : '0;
    end

    // Running burst issues one column each clock
    unique case (q.fsm)
      sdbmd_pkg::SDBMD_RD,
      sdbmd_pkg::SDBMD_WR: begin
        d.beat      = beat_nx;
        d.arr.valid = 1'b1;
        d.arr.col   = col_next;
        d.arr.wdata = dq_in;
        d.arr.wmask = dqm;  // Write mask acts at once
        if (beat_nx == q.last) begin
          d.fsm = sdbmd_pkg::SDBMD_IDLE;
          // Auto precharge closes the bank on the edge that issues the last beat
          if (q.auto_pre) begin
            d.bank_open[q.bank] = 1'b0;
          end
        end
      end
      sdbmd_pkg::SDBMD_SELF: begin
        // Stays asleep until clock enable returns high
        if (cke) begin
          d.fsm = sdbmd_pkg::SDBMD_IDLE;
        end
      end
      sdbmd_pkg::SDBMD_IDLE: begin
        d.beat = q.beat;
      end
    endcase

    // New commands; during self refresh the pins are ignored
    if (q.fsm != sdbmd_pkg::SDBMD_SELF) begin
      if (c_act) begin
        d.bank_open[bsel] = 1'b1;
        d.open_row[bsel]  = addr;
      end
      // Bursts are refused outside the normal operating mode
      if ((c_rd || c_wr) && normal) begin
        d.start       = col_cmd;
        d.beat        = '0;
        d.bank        = bsel;
        d.auto_pre    = addr[`SDBMD_AP_BIT];
        d.arr.valid   = 1'b1;
        d.arr.write   = c_wr;
        d.arr.bank    = bsel;
        d.arr.row     = q.open_row[bsel];
        d.arr.col     = col_cmd;
        d.arr.wdata   = dq_in;
        d.arr.wmask   = dqm;
        // Single-location writes when the write mode bit is set
        if (c_wr && q.mode[`SDBMD_WB_BIT]) begin
          d.last = '0;
        end else begin
          d.last = bl_last;
        end
        if (d.last == '0) begin
          d.fsm = sdbmd_pkg::SDBMD_IDLE;
          if (addr[`SDBMD_AP_BIT]) begin
            d.bank_open[bsel] = 1'b0;
          end
        end else begin
          d.fsm = c_wr ? sdbmd_pkg::SDBMD_WR : sdbmd_pkg::SDBMD_RD;
        end
      end
      // Terminate stops column issue after the column issued on its own edge; data in flight still leaves
      if (c_bst) begin
        d.fsm = sdbmd_pkg::SDBMD_IDLE;
      end
      if (c_pre) begin
        if (addr[`SDBMD_AP_BIT]) begin
          d.bank_open = '0;
        end else begin
          d.bank_open[bsel] = 1'b0;
        end
      end
      if (c_ref) begin
        d.ref_row = q.ref_row + 1'b1;
        if (cke) begin
          d.arr.valid   = 1'b1;
          d.arr.refresh = 1'b1;
          d.arr.write   = 1'b0;
          d.arr.row     = q.ref_row;
        end else begin
          d.fsm = sdbmd_pkg::SDBMD_SELF;
        end
      end
      // Controller keeps banks idle here, so no burst is cut
      if (c_mrs) begin
        d.mode     = addr;
        d.mode_bad =
          (addr[`SDBMD_OPM_MSB:`SDBMD_OPM_LSB] != `SDBMD_OPM_NORMAL)
          || ((addr[`SDBMD_RL_MSB:`SDBMD_RL_LSB] != `SDBMD_RL_2)
          && (addr[`SDBMD_RL_MSB:`SDBMD_RL_LSB] != `SDBMD_RL_3));
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Clock enable low freezes every flop
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q      <= '0;
      q.fsm  <= sdbmd_pkg::SDBMD_IDLE;
      q.mode <= `SDBMD_MODE_RST;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign dq_out        = q.dq_out;
  assign dq_oe         = q.dq_oe;
  assign arr_req       = q.arr;
  assign bank_open     = q.bank_open;
  assign self_refresh  = (q.fsm == sdbmd_pkg::SDBMD_SELF);
  assign mode_reserved = q.mode_bad;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk iff clk_en);
  endclocking
  default disable iff (!rstn);

  // Bursts of four, sequential, from the pins
  sequence s_rd4_seq;
    c_rd && normal && (bl_code == `SDBMD_BL_4)
    && !q.mode[`SDBMD_BT_BIT] && (q.fsm != sdbmd_pkg::SDBMD_SELF);
  endsequence

  // Bursts of eight, interleaved
  sequence s_rd8_ilv;
    c_rd && normal && (bl_code == `SDBMD_BL_8)
    && q.mode[`SDBMD_BT_BIT] && (q.fsm != sdbmd_pkg::SDBMD_SELF);
  endsequence

  // No new command: deselect or no operation
  sequence s_quiet;
    cmd.cs_n || (cmd.ras_n && cmd.cas_n && cmd.we_n);
  endsequence

  a_mode_load_val: assert property (
    (c_mrs && q.fsm != sdbmd_pkg::SDBMD_SELF) |=> q.mode == $past(addr))
    else $error("mode load did not store address");

  a_rd_first_col: assert property (
    (c_rd && normal && q.fsm != sdbmd_pkg::SDBMD_SELF)
    |=> arr_req.valid && !arr_req.write && arr_req.col == $past(col_cmd))
    else $error("read start column wrong");

  a_lat_two_drive: assert property (
    (c_rd && normal && !lat3 && !dqm[0]
     && q.fsm != sdbmd_pkg::SDBMD_SELF) |=> ##1 dq_oe[0])
    else $error("latency two data not driven at n+1");

  // Mask two edges before first data counts; a reload would move it
  a_lat_three_drive: assert property (
    (c_rd && normal && lat3 && q.fsm != sdbmd_pkg::SDBMD_SELF)
    ##1 (!dqm[0] && !c_mrs) |=> ##1 dq_oe[0])
    else $error("latency three data not driven at n+2");

  a_wrap_seq_four: assert property (
    s_rd4_seq ##1 s_quiet |=>
    arr_req.col == (($past(col_cmd, 2) & ~`SDBMD_LAST_4)
      | (($past(col_cmd, 2) + 1'b1) & `SDBMD_LAST_4)))
    else $error("sequential four did not wrap in block");

  a_ilv_eight_beat: assert property (
    s_rd8_ilv ##1 s_quiet |=>
    arr_req.col == ($past(col_cmd, 2) ^ `SDBMD_COL_MAX'(1)))
    else $error("interleaved eight second column wrong");

  a_single_write: assert property (
    (c_wr && normal && q.mode[`SDBMD_WB_BIT]
     && q.fsm != sdbmd_pkg::SDBMD_SELF)
    |=> q.fsm == sdbmd_pkg::SDBMD_IDLE)
    else $error("single write mode still bursting");

  a_precharge_all: assert property (
    (c_pre && addr[`SDBMD_AP_BIT] && !c_act
     && q.fsm != sdbmd_pkg::SDBMD_SELF) |=> bank_open == '0)
    else $error("precharge all left a bank open");

  a_refresh_row: assert property (
    (c_ref && cke && q.fsm != sdbmd_pkg::SDBMD_SELF)
    |=> arr_req.refresh && arr_req.row == $past(q.ref_row)
        && q.ref_row == $past(q.ref_row) + 12'h001)
    else $error("refresh row not from counter");

  a_self_entry: assert property (
    (c_ref && !cke && q.fsm != sdbmd_pkg::SDBMD_SELF)
    |=> self_refresh && !arr_req.valid)
    else $error("self refresh not entered");

  a_write_mask: assert property (
    (c_wr && normal && q.fsm != sdbmd_pkg::SDBMD_SELF)
    |=> arr_req.write && arr_req.wmask == $past(dqm))
    else $error("write mask not taken with data");

endmodule

`default_nettype wire

//--- sdbmd_cfg.svh
// Operation
// - Burst type comes from mode bit three.
// - Length two: column bit zero starts pair.
// - Length four: increment or XOR within block.
// - Length eight: increment or XOR within block.
// - Bursts wrap inside their aligned block.
// - Full page: any start, sequential, wraps page.
// - Page is 2048, 1024 or 512 columns.
// - Read latency programmable to two or three.
// - Drive from edge n+m-1, valid by n+m.
// - Operating mode bits must both be zero.
// - Mode bit nine forces single-location writes.
// - Commands decoded from four active-low strobes.
// - Activate takes row and bank pins.
// - Read/write take column; bit ten auto-precharges.
// - Precharge one bank, or all when bit ten.
// - Refresh pattern: auto, or self when enable low.
// - Internal counter supplies the refresh row.
// - Mode load stores the twelve address pins.
// - Byte mask: zero delay write, two read.
// - Mode fields: length, type, latency, reserved.
`ifndef SDBMD_CFG_SVH
`define SDBMD_CFG_SVH

// ****************************************************************
// Mode register layout
// ****************************************************************
`define SDBMD_MODE_RST   12'h000
`define SDBMD_BL_LSB     0
`define SDBMD_BL_MSB     2
`define SDBMD_BT_BIT     3
`define SDBMD_RL_LSB     4
`define SDBMD_RL_MSB     6
`define SDBMD_OPM_LSB    7
`define SDBMD_OPM_MSB    8
`define SDBMD_WB_BIT     9
`define SDBMD_AP_BIT     10

// ****************************************************************
// Field codes
// ****************************************************************
`define SDBMD_BL_1       3'h0
`define SDBMD_BL_2       3'h1
`define SDBMD_BL_4       3'h2
`define SDBMD_BL_8       3'h3
`define SDBMD_BL_FULL    3'h7
`define SDBMD_RL_2       3'h2
`define SDBMD_RL_3       3'h3
`define SDBMD_OPM_NORMAL 2'h0

// ****************************************************************
// Burst spans minus one, and widths
// ****************************************************************
`define SDBMD_LAST_2     11'h001
`define SDBMD_LAST_4     11'h003
`define SDBMD_LAST_8     11'h007
`define SDBMD_DQ_MAX     16
`define SDBMD_DM_MAX     2
`define SDBMD_COL_MAX    11

`endif

//--- sdbmd_pkg.sv
`default_nettype none
`include "sdbmd_cfg.svh"

package sdbmd_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  // Command strobes, all active low
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdbmd_pins_t;

  // One-hot control states
  typedef enum logic [3:0] {
    SDBMD_IDLE  = 4'h1,
    SDBMD_RD    = 4'h2,
    SDBMD_WR    = 4'h4,
    SDBMD_SELF  = 4'h8
  } sdbmd_fsm_t;

  // Request to the cell array, one per column beat or refresh
  typedef struct packed {
    logic                            valid;
    logic                            write;
    logic                            refresh;
    logic [1:0]                      bank;
    logic [11:0]                     row;
    logic [`SDBMD_COL_MAX-1:0]       col;
    logic [`SDBMD_DQ_MAX-1:0]        wdata;
    logic [`SDBMD_DM_MAX-1:0]        wmask;
  } sdbmd_arr_t;

  // Whole state of the decoder
  typedef struct packed {
    sdbmd_fsm_t                      fsm;
    logic [11:0]                     mode;
    logic                            mode_bad;
    logic [`SDBMD_COL_MAX-1:0]       start;
    logic [`SDBMD_COL_MAX-1:0]       beat;
    logic [`SDBMD_COL_MAX-1:0]       last;
    logic [1:0]                      bank;
    logic                            auto_pre;
    logic [3:0][11:0]                open_row;
    logic [3:0]                      bank_open;
    logic [11:0]                     ref_row;
    logic [`SDBMD_DM_MAX-1:0]        dqm_q1;
    logic [`SDBMD_DQ_MAX-1:0]        rd_data;
    logic                            rd_vld;
    sdbmd_arr_t                      arr;
    logic [`SDBMD_DQ_MAX-1:0]        dq_out;
    logic [`SDBMD_DM_MAX-1:0]        dq_oe;
  } sdbmd_state_t;

endpackage

`default_nettype wire

//--- sdbmd_order.sv
`default_nettype none
`include "sdbmd_cfg.svh"

// ****************************************************************
// Column order within a burst
// ****************************************************************
module sdbmd_order #(
  parameter int COL_W = 9
) (
  input  wire logic [`SDBMD_COL_MAX-1:0] start,
  input  wire logic [`SDBMD_COL_MAX-1:0] beat,
  input  wire logic [2:0]                bl_code,
  input  wire logic                      ilv,
  input  wire logic [`SDBMD_COL_MAX-1:0] page_mask,
  output logic      [`SDBMD_COL_MAX-1:0] col
);

  // Column width must fit the shared column bus
  if (COL_W < 1 || COL_W > `SDBMD_COL_MAX) begin : g_bad_col
    $error("COL_W out of range");
  end

  logic [`SDBMD_COL_MAX-1:0] blk_mask;  // Bits that move inside a block
  logic [`SDBMD_COL_MAX-1:0] moved;     // Low bits after stepping
  logic                      use_xor;   // Interleaved stepping

  // Block size picks which low bits move; the rest stay fixed
  always_comb begin
    unique case (bl_code)
      `SDBMD_BL_2:    blk_mask = `SDBMD_LAST_2;
      `SDBMD_BL_4:    blk_mask = `SDBMD_LAST_4;
      `SDBMD_BL_8:    blk_mask = `SDBMD_LAST_8;
      `SDBMD_BL_FULL: blk_mask = page_mask;
      default:        blk_mask = '0;
    endcase
  end

  // Full page has no interleaved form, so it always increments
  assign use_xor = ilv && (bl_code != `SDBMD_BL_FULL);
  assign moved   = use_xor ? (start ^ beat) : (start + beat);
  // Fixed bits keep the block, so a burst wraps and never crosses
  assign col = ((start & ~blk_mask) | (moved & blk_mask)) & page_mask;

endmodule

`default_nettype wire

//--- sdbmd_ctl_model.sv
`default_nettype none

// ****************************************************************
// Memory controller model with a small array stub
// ****************************************************************
module sdbmd_ctl_model (
  input  wire logic                   core_clk,
  input  wire sdbmd_pkg::sdbmd_arr_t  arr_req,
  output var  sdbmd_pkg::sdbmd_pins_t cmd,
  output var  logic                   bank_select_0,
  output var  logic                   bank_select_1,
  output var  logic [11:0]            addr,
  output var  logic [1:0]             dqm,
  output var  logic [15:0]            dq_in,
  output var  logic                   cke,
  output logic      [15:0]            arr_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int MRD_CYC = 2;  // Mode-register delay, plain default

  // Data carries its column, so a beat read out of order shows up
  assign arr_rdata = {5'h15, arr_req.col};

  // Deselected at time zero
  initial begin
    cmd = sdbmd_pkg::sdbmd_pins_t'(4'hf);
    {bank_select_1, bank_select_0} = 2'h0;
    addr = 12'h000;
    dqm = 2'h0;
    dq_in = 16'h0000;
    cke = 1'b1;
  end

  // One command for one edge; then no operation, with address and data inverted
  task automatic issue(input logic [3:0] c, input logic [1:0] ba,
                       input logic [11:0] a, input logic [1:0] m,
                       input logic [15:0] d, input logic ck);
    @(posedge core_clk);
    cmd <= sdbmd_pkg::sdbmd_pins_t'(c);
    {bank_select_1, bank_select_0} <= ba;
    addr <= a;
    dqm <= m;
    dq_in <= d;
    cke <= ck;
    @(posedge core_clk);
    cmd <= sdbmd_pkg::sdbmd_pins_t'(4'h7);
    addr <= ~a;
    dq_in <= ~d;
    dqm <= 2'h0;
    cke <= 1'b1;
  endtask

  // Close all banks, load, wait, then reopen bank 0 for bursts
  task automatic load_mode(input logic [11:0] m);
    issue(4'h2, 2'h3, 12'h400, 2'h0, 16'h0000, 1'b1);
    issue(4'h0, 2'h0, m, 2'h0, 16'h0000, 1'b1);
    repeat (MRD_CYC) @(posedge core_clk);
    issue(4'h3, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b1);
  endtask
endmodule

`default_nettype wire

//--- sdbmd_tb_top.sv
`default_nettype none

module sdbmd_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic                   core_clk;
  logic                   rstn;
  logic                   clk_en;  // Low freezes the design
  logic                   cke;
  sdbmd_pkg::sdbmd_pins_t cmd;
  logic                   bs0;
  logic                   bs1;
  logic [11:0]            addr;
  logic [1:0]             dqm;
  logic [15:0]            dq_in;
  logic [15:0]            arr_rdata;
  logic [15:0]            dq_out;
  logic [1:0]             dq_oe;
  sdbmd_pkg::sdbmd_arr_t  arr_req;
  logic [3:0]             bank_open;
  logic                   self_refresh;
  logic                   mode_reserved;
  int                     failures = 0;
  int                     n_tests = 0;

  sdbmd_top #(.DQ_W(16)) dut (
    .core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .cke(cke),
    .cmd(cmd), .bank_select_0(bs0), .bank_select_1(bs1), .addr(addr),
    .dqm(dqm), .dq_in(dq_in), .arr_rdata(arr_rdata), .dq_out(dq_out),
    .dq_oe(dq_oe), .arr_req(arr_req), .bank_open(bank_open),
    .self_refresh(self_refresh), .mode_reserved(mode_reserved));

  sdbmd_ctl_model ctl (
    .core_clk(core_clk), .arr_req(arr_req), .cmd(cmd),
    .bank_select_0(bs0), .bank_select_1(bs1), .addr(addr), .dqm(dqm),
    .dq_in(dq_in), .cke(cke), .arr_rdata(arr_rdata));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic end_sim();
    if (failures == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Step past an edge so its updates have landed
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  // Column of beat k: wrap in the aligned block, or XOR the count
  function automatic logic [10:0] col_at(input logic [10:0] st,
      input logic [10:0] msk, input logic ilv, input int k);
    return ilv ? (st ^ 11'(k)) : ((st & ~msk) | ((st + 11'(k)) & msk));
  endfunction

  // Read on bank 0; n > 8 means full page, checked for n beats only
  task automatic rd_burst(input logic [8:0] st, input int n, input int m,
                          input logic ilv, input logic ap,
                          input logic [1:0] oe1);
    logic [10:0] msk;
    int          j;
    msk = (n > 8) ? 11'h1ff : 11'(n - 1);
    ctl.issue(4'h5, 2'h0, {1'b0, ap, 1'b0, st}, ~oe1, 16'h0000, 1'b1);
    for (int k = 0; k < n + m; k++) begin
      #1;
      j = k - (m - 1);
      if (k < n) begin
        chk(arr_req.col, col_at({2'h0, st}, msk, ilv, k));
        chk(arr_req.valid, 1'b1);
      end else if (n <= 8) begin
        chk(arr_req.valid, 1'b0);
      end
      // Mask given with the command gates the data two edges later
      if (j >= 0 && j < n) begin
        chk(dq_oe, (j == 2 - m) ? oe1 : 2'h3);
      end
      if (j >= 0 && j < n && (j != 2 - m || oe1 == 2'h3)) begin
        chk(dq_out, {5'h15, col_at({2'h0, st}, msk, ilv, j)});
      end
      if (j == n && n <= 8) begin
        chk(dq_oe, 2'h0);
      end
      @(posedge core_clk);
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_refresh();
    int i;
    ctl.issue(4'h1, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b1);
    #1;
    chk(arr_req.refresh, 1'b1);
    chk(arr_req.row, 12'h000);
    ctl.issue(4'h1, 2'h3, 12'hfff, 2'h0, 16'h0000, 1'b1);
    #1;
    chk(arr_req.row, 12'h001);
    ctl.issue(4'h1, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b0);
    #1;
    chk(self_refresh, 1'b1);
    for (i = 0; i < 4 && self_refresh !== 1'b0; i++) begin
      tick();
    end
    if (self_refresh !== 1'b0) begin
      failures++;
      end_sim();
    end
    ctl.issue(4'h1, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b1);
    #1;
    chk(arr_req.row, 12'h003);
  endtask

  task automatic t_banks();
    ctl.load_mode(12'h022);
    ctl.issue(4'h3, 2'h2, 12'h5a5, 2'h0, 16'h0000, 1'b1);
    #1;
    chk(bank_open, 4'h5);
    ctl.issue(4'h2, 2'h2, 12'h000, 2'h0, 16'h0000, 1'b1);
    #1;
    chk(bank_open, 4'h1);
    ctl.issue(4'h2, 2'h2, 12'h400, 2'h0, 16'h0000, 1'b1);
    #1;
    chk(bank_open, 4'h0);
    ctl.issue(4'h3, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b1);
  endtask

  task automatic t_short();
    ctl.load_mode(12'h022);
    rd_burst(9'h001, 4, 2, 1'b0, 1'b0, 2'h1);
    ctl.load_mode(12'h02b);
    rd_burst(9'h0a5, 8, 2, 1'b1, 1'b0, 2'h3);
    ctl.load_mode(12'h033);
    rd_burst(9'h0a5, 8, 3, 1'b0, 1'b0, 2'h3);
    ctl.load_mode(12'h039);
    rd_burst(9'h003, 2, 3, 1'b1, 1'b1, 2'h3);
    tick();
    chk(bank_open, 4'h0);
  endtask

  task automatic t_page();
    ctl.load_mode(12'h027);
    rd_burst(9'h1fe, 10, 2, 1'b0, 1'b0, 2'h3);
    ctl.issue(4'h6, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b1);
    repeat (3) tick();
    chk(arr_req.valid, 1'b0);
    chk(dq_oe, 2'h0);
  endtask

  task automatic t_write();
    ctl.load_mode(12'h222);
    ctl.issue(4'h4, 2'h0, 12'h003, 2'h1, 16'h5a3c, 1'b1);
    #1;
    chk(arr_req.write, 1'b1);
    chk(arr_req.col, 11'h003);
    chk(arr_req.wdata, 16'h5a3c);
    chk(arr_req.wmask, 2'h1);
    repeat (3) begin
      tick();
      chk(arr_req.valid, 1'b0);
    end
  endtask

  // Clock enable low holds state; a reset in mid-run clears it
  task automatic t_freeze();
    ctl.load_mode(12'h022);
    clk_en <= 1'b0;
    ctl.issue(4'h3, 2'h3, 12'h000, 2'h0, 16'h0000, 1'b1);
    #1;
    chk(bank_open, 4'h1);
    @(posedge core_clk);
    clk_en <= 1'b1;
    ctl.issue(4'h3, 2'h3, 12'h000, 2'h0, 16'h0000, 1'b1);
    #1;
    chk(bank_open, 4'h9);
    @(posedge core_clk);
    rstn <= 1'b0;
    tick();
    chk(bank_open, 4'h0);
    chk(dq_oe, 2'h0);
    @(posedge core_clk);
    rstn <= 1'b1;
  endtask

  task automatic t_reserved();
    ctl.load_mode(12'h0a2);
    tick();
    chk(mode_reserved, 1'b1);
    ctl.issue(4'h5, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b1);
    repeat (3) begin
      #1;
      chk(arr_req.valid, 1'b0);
      @(posedge core_clk);
    end
    ctl.load_mode(12'h022);
    tick();
    chk(mode_reserved, 1'b0);
  endtask

  // ****************************************************************
  // Clock and main sequence
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    rstn = 1'b0;
    clk_en = 1'b1;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    t_refresh();
    t_banks();
    t_short();
    t_page();
    t_write();
    t_freeze();
    t_reserved();
    end_sim();
  end
endmodule

`default_nettype wire
